/* File: csc_regs.sv */
// Overview of operation
// R1 - Auto-control enables fast, gain, balance, exposure
// R2 - Step bit limits fast exposure change
// R3 - Banding filter switch and sub-line exposure
// R4 - Gain ceiling field caps automatic gain
// R5 - Allow exposure below banding limit
// R6 - Vertical sync dropped with dropped frames
// R7 - Drop frame when step exceeds gap
// R8 - Reset and power-down pins become slave syncs
// R9 - Line-valid swap and sync polarity inversion
// R10 - Pixel clock gated while line-valid low
// R11 - SAV position and blanking fill bytes
// R12 - Dummy frame above selected gain threshold
// R13 - Horizontal window edges are 11 bits
// R14 - Vertical window edges are 11 bits
// R15 - Pixel delay of data versus line-valid
// R16 - Read-only identification bytes ignore writes
// R17 - Black-level offsets sign and magnitude
// R18 - Window edges rewritten on mode change
// R19 - Long-step option overrides step limit
// R20 - Reserved bits stored, no effect
// R21 - Byte access, effective at next frame
module csc_regs (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  input wire logic frameStart,
  input wire logic longStepOption,
  input wire logic windowAutoUpdate,
  input wire logic modeChange,
  input wire logic [7:0] modeHStart,
  input wire logic [7:0] modeHEnd,
  input wire logic [7:0] modeVStart,
  input wire logic [7:0] modeVEnd,
  input wire logic [5:0] lineValidLow,
  input wire logic [5:0] vertRefLow,
  input wire logic [7:0] gainReq,
  input wire logic [15:0] expStep,
  input wire logic [15:0] expGap,
  input wire logic lineValidRaw,
  input wire logic hsyncRaw,
  input wire logic vsyncRaw,
  input wire logic pclkRaw,
  input wire logic resetPinN,
  input wire logic powerDownPin,
  output logic fastAlgoEn,
  output logic agcEn,
  output logic awbEn,
  output logic aecEn,
  output logic stepLimitVsync,
  output logic bandFilterEn,
  output logic subLineExpEn,
  output logic bandLimitOverride,
  output logic [7:0] gainCapped,
  output logic frameDropReq,
  output logic dummyFrameReq,
  output logic [1:0] savPosition,
  output logic blankFillEn,
  output logic [10:0] hWinStart,
  output logic [10:0] hWinEnd,
  output logic [10:0] vWinStart,
  output logic [10:0] vWinEnd,
  output logic [7:0] pixelDelay,
  output logic mirrorEn,
  output logic flipEn,
  output logic [7:0] blueOffset,
  output logic [7:0] greenBOffset,
  output logic lineValidOut,
  output logic hsyncOut,
  output logic vsyncOut,
  output logic pclkOut,
  output logic sensorResetReq,
  output logic powerDownReq,
  output logic slaveHorizSync,
  output logic slaveVertSync
);
  // Host-visible registers and frame-aligned working copies
  logic [7:0] regs [csc_pkg::CSC_NREG];
  logic [7:0] live [csc_pkg::CSC_NREG];
  // Serial slave state
  csc_pkg::csc_state_t state;
  logic sclQ, sdaQ, sclP, sdaP;
  logic [3:0] bitCnt;
  logic [7:0] shiftIn;
  logic [7:0] txByte;
  logic [7:0] subAddr;
  logic readDir;
  logic wrStb;
  logic [7:0] wrAddr;
  logic [7:0] wrData;
  logic sclRise, sclFall, busStart, busStop;
  logic [7:0] gainCeil;
  logic [7:0] dummyThr;

  // Offset inside the slice
  function automatic logic inSlice(input logic [7:0] a);
    inSlice = (a >= csc_pkg::CSC_FIRST) && (a <= csc_pkg::CSC_LAST);
  endfunction : inSlice

  // Index of an offset
  function automatic logic [3:0] idxOf(input logic [7:0] a);
    logic [7:0] d;
    d = a - csc_pkg::CSC_FIRST;
    idxOf = d[3:0];
  endfunction : idxOf

  // Read data for an offset
  function automatic logic [7:0] readReg(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == csc_pkg::CSC_MAKER_CODE_HIGH) begin
      v = csc_pkg::CSC_MAKER_HI;
    end else if (a == csc_pkg::CSC_MAKER_CODE_LOW) begin
      v = csc_pkg::CSC_MAKER_LO;
    end else if (inSlice(a)) begin
      v = regs[idxOf(a)];
    end
    readReg = v;
  endfunction : readReg

  // Bus line events from sampled levels
  assign sclRise = sclQ & ~sclP;
  assign sclFall = ~sclQ & sclP;
  assign busStart = sclQ & sclP & sdaP & ~sdaQ;
  assign busStop = sclQ & sclP & ~sdaP & sdaQ;

  // Sample and remember bus lines
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sclQ <= 1'b1;
      sdaQ <= 1'b1;
      sclP <= 1'b1;
      sdaP <= 1'b1;
    end else begin
      sclQ <= sclIn;
      sdaQ <= sdaIn;
      sclP <= sclQ;
      sdaP <= sdaQ;
    end
  end

  // Serial slave sequencer
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= csc_pkg::CSC_IDLE;
      bitCnt <= 4'h0;
      shiftIn <= 8'h00;
      txByte <= 8'h00;
      subAddr <= 8'h00;
      readDir <= 1'b0;
    end else if (busStart) begin
      // Start or repeated start
      state <= csc_pkg::CSC_DEV;
      bitCnt <= 4'h0;
    end else if (busStop) begin
      state <= csc_pkg::CSC_IDLE;
    end else if (sclRise) begin
      // Shift in on rising clock
      if (state == csc_pkg::CSC_DEV || state == csc_pkg::CSC_SUB ||
          state == csc_pkg::CSC_WR) begin
        shiftIn <= {shiftIn[6:0], sdaQ};
        bitCnt <= bitCnt + 4'h1;
      end else if (state == csc_pkg::CSC_RDACK && sdaQ) begin
        // Master ends the read
        state <= csc_pkg::CSC_SKIP;
      end
    end else if (sclFall) begin
      case (state)
        csc_pkg::CSC_DEV: begin
          if (bitCnt == 4'h8) begin
            readDir <= shiftIn[0];
            state <= (shiftIn[7:1] == csc_pkg::CSC_DEV_ADDR) ?
                     csc_pkg::CSC_DEVACK : csc_pkg::CSC_SKIP;
          end
        end
        csc_pkg::CSC_DEVACK: begin
          bitCnt <= 4'h0;
          if (readDir) begin
            txByte <= readReg(subAddr);
            state <= csc_pkg::CSC_RD;
          end else begin
            state <= csc_pkg::CSC_SUB;
          end
        end
        csc_pkg::CSC_SUB: begin
          if (bitCnt == 4'h8) begin
            subAddr <= shiftIn;
            state <= csc_pkg::CSC_SUBACK;
          end
        end
        csc_pkg::CSC_SUBACK, csc_pkg::CSC_WRACK: begin
          bitCnt <= 4'h0;
          state <= csc_pkg::CSC_WR;
        end
        csc_pkg::CSC_WR: begin
          if (bitCnt == 4'h8) begin
            state <= csc_pkg::CSC_WRACK;
            subAddr <= subAddr + 8'h01;
          end
        end
        csc_pkg::CSC_RD: begin
          // Shift out on falling clock
          if (bitCnt == 4'h7) begin
            state <= csc_pkg::CSC_RDACK;
            subAddr <= subAddr + 8'h01;
          end else begin
            txByte <= {txByte[6:0], 1'b0};
            bitCnt <= bitCnt + 4'h1;
          end
        end
        csc_pkg::CSC_RDACK: begin
          // Acknowledged, next byte follows
          bitCnt <= 4'h0;
          txByte <= readReg(subAddr);
          state <= csc_pkg::CSC_RD;
        end
        default: begin
          state <= state;
        end
      endcase
    end
  end

  // R21 byte write strobe
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wrStb <= 1'b0;
      wrAddr <= 8'h00;
      wrData <= 8'h00;
    end else begin
      wrStb <= sclFall && !busStart && !busStop &&
               state == csc_pkg::CSC_WR && bitCnt == 4'h8;
      wrAddr <= subAddr;
      wrData <= shiftIn;
    end
  end

  // Open-drain data line, low enable drives low
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sdaOut <= 1'b0;
      sdaOeN <= 1'b1;
    end else begin
      sdaOut <= 1'b0;
      sdaOeN <= !(state == csc_pkg::CSC_DEVACK ||
                  state == csc_pkg::CSC_SUBACK ||
                  state == csc_pkg::CSC_WRACK ||
                  (state == csc_pkg::CSC_RD && !txByte[7]));
    end
  end

  // Register storage and frame-aligned copies
  for (genvar i = 0; i < csc_pkg::CSC_NREG; i++) begin : g_reg
    localparam logic [7:0] OFS = csc_pkg::CSC_FIRST + 8'(i);
    localparam logic IS_WIN = (OFS >= csc_pkg::CSC_HORIZ_WINDOW_START) &&
                              (OFS <= csc_pkg::CSC_VERT_WINDOW_END);
    logic [7:0] modeVal;
    assign modeVal = (OFS == csc_pkg::CSC_HORIZ_WINDOW_START) ? modeHStart :
                     (OFS == csc_pkg::CSC_HORIZ_WINDOW_END) ? modeHEnd :
                     (OFS == csc_pkg::CSC_VERT_WINDOW_START) ? modeVStart :
                     modeVEnd;
    // Host write, mode-change update
    always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
        regs[i] <= csc_pkg::CSC_RST[i];
      end else if (wrStb && wrAddr == OFS &&
                   OFS != csc_pkg::CSC_MAKER_CODE_HIGH &&
                   OFS != csc_pkg::CSC_MAKER_CODE_LOW) begin
        // R16 identification bytes ignore writes
        // R20 reserved bits stored as written
        regs[i] <= wrData;
      end else if (IS_WIN && windowAutoUpdate && modeChange) begin
        // R18 window auto rewrite
        regs[i] <= modeVal;
      end
    end
    // R21 takes effect at frame start
    always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
        live[i] <= csc_pkg::CSC_RST[i];
      end else if (frameStart) begin
        live[i] <= regs[i];
      end
    end
  end

  // Gain ceiling and dummy threshold decode
  always_comb begin
    // R4 ceiling doubles per code up to 6, code 7 gives the same maximum
    gainCeil = csc_pkg::CSC_GAIN_MAX;
    if (live[1][csc_pkg::GC_CEIL+:3] != 3'h7) begin
      gainCeil = 8'h02 << live[1][csc_pkg::GC_CEIL+:3];
    end
    // R12 threshold select
    case (live[3][csc_pkg::OO_DUMMY+:2])
      2'b00: dummyThr = csc_pkg::CSC_DUMMY_2X;
      2'b01: dummyThr = csc_pkg::CSC_DUMMY_4X;
      default: dummyThr = csc_pkg::CSC_DUMMY_8X;
    endcase
  end

  // Exposure and gain control outputs
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      fastAlgoEn <= 1'b0;
      agcEn <= 1'b0;
      awbEn <= 1'b0;
      aecEn <= 1'b0;
      stepLimitVsync <= 1'b0;
      bandFilterEn <= 1'b0;
      subLineExpEn <= 1'b0;
      bandLimitOverride <= 1'b0;
      gainCapped <= 8'h00;
      frameDropReq <= 1'b0;
      dummyFrameReq <= 1'b0;
    end else begin
      // R1 algorithm enables
      fastAlgoEn <= live[0][csc_pkg::AC_FAST];
      agcEn <= live[0][csc_pkg::AC_AGC];
      awbEn <= live[0][csc_pkg::AC_AWB];
      aecEn <= live[0][csc_pkg::AC_AEC];
      // R2 R19 step limit in fast mode
      stepLimitVsync <= live[0][csc_pkg::AC_FAST] && !longStepOption &&
                        !live[0][csc_pkg::AC_STEP];
      // R3 banding and sub-line exposure
      bandFilterEn <= live[0][csc_pkg::AC_BAND];
      subLineExpEn <= live[0][csc_pkg::AC_SUBLINE];
      // R5 strong-light override
      bandLimitOverride <= live[1][csc_pkg::GC_BANDOVR];
      // R4 clamp gain to ceiling
      gainCapped <= (gainReq > gainCeil) ? gainCeil : gainReq;
      // R7 drop on oversize step
      frameDropReq <= live[1][csc_pkg::GC_DROP] && (expStep > expGap);
      // R12 dummy frame above threshold
      dummyFrameReq <= gainReq > dummyThr;
    end
  end

  // Format, window and offset outputs
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      savPosition <= 2'h0;
      blankFillEn <= 1'b0;
      hWinStart <= 11'h000;
      hWinEnd <= 11'h000;
      vWinStart <= 11'h000;
      vWinEnd <= 11'h000;
      pixelDelay <= 8'h00;
      mirrorEn <= 1'b0;
      flipEn <= 1'b0;
      blueOffset <= 8'h00;
      greenBOffset <= 8'h00;
    end else begin
      // R11 SAV position and fill bytes
      savPosition <= live[3][csc_pkg::OO_SAV+:2];
      blankFillEn <= live[3][csc_pkg::OO_BLANK];
      // R13 horizontal edges
      hWinStart <= {live[4], lineValidLow[2:0]};
      hWinEnd <= {live[5], lineValidLow[5:3]};
      // R14 vertical edges
      vWinStart <= {live[6], vertRefLow[2:0]};
      vWinEnd <= {live[7], vertRefLow[5:3]};
      // R15 pixel delay
      pixelDelay <= live[8];
      mirrorEn <= live[11][csc_pkg::MF_MIRROR];
      flipEn <= live[11][csc_pkg::MF_FLIP];
      // R17 sign and magnitude offsets
      blueOffset <= live[13];
      greenBOffset <= live[14];
    end
  end

  // Sync and pixel clock outputs
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      lineValidOut <= 1'b0;
      hsyncOut <= 1'b0;
      vsyncOut <= 1'b0;
      pclkOut <= 1'b0;
    end else begin
      // R9 line-valid swap and inversion
      lineValidOut <= (live[2][csc_pkg::SO_HSYNC] ? hsyncRaw : lineValidRaw) ^
                      live[2][csc_pkg::SO_LVINV];
      hsyncOut <= hsyncRaw ^ live[2][csc_pkg::SO_HSINV];
      // R6 suppress sync on dropped frame
      vsyncOut <= (vsyncRaw && !(live[1][csc_pkg::GC_VDROP] && frameDropReq)) ^
                  live[2][csc_pkg::SO_VSINV];
      // R10 gate clock outside line-valid
      pclkOut <= (pclkRaw && (!live[2][csc_pkg::SO_PGATE] || lineValidRaw)) ^
                 live[2][csc_pkg::SO_PINV];
    end
  end

  // Pin redefinition for slave mode
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sensorResetReq <= 1'b0;
      powerDownReq <= 1'b0;
      slaveHorizSync <= 1'b0;
      slaveVertSync <= 1'b0;
    end else begin
      // R8 pins carry slave syncs
      if (live[2][csc_pkg::SO_SLAVE]) begin
        sensorResetReq <= 1'b0;
        powerDownReq <= 1'b0;
        slaveHorizSync <= !resetPinN;
        slaveVertSync <= powerDownPin;
      end else begin
        sensorResetReq <= !resetPinN;
        powerDownReq <= powerDownPin;
        slaveHorizSync <= 1'b0;
        slaveVertSync <= 1'b0;
      end
    end
  end
endmodule : csc_regs

/* File: csc_pkg.sv */
package csc_pkg;
  // Register offsets on the serial control bus
  localparam logic [7:0] CSC_FIRST = 8'h13;
  localparam logic [7:0] CSC_LAST = 8'h21;
  localparam logic [7:0] CSC_AUTO_CONTROL = 8'h13;
  localparam logic [7:0] CSC_GAIN_CEILING_CTRL = 8'h14;
  localparam logic [7:0] CSC_SYNC_OUTPUT_CTRL = 8'h15;
  localparam logic [7:0] CSC_OUTPUT_OPTION_CTRL = 8'h16;
  localparam logic [7:0] CSC_HORIZ_WINDOW_START = 8'h17;
  localparam logic [7:0] CSC_HORIZ_WINDOW_END = 8'h18;
  localparam logic [7:0] CSC_VERT_WINDOW_START = 8'h19;
  localparam logic [7:0] CSC_VERT_WINDOW_END = 8'h1a;
  localparam logic [7:0] CSC_PIXEL_DELAY = 8'h1b;
  localparam logic [7:0] CSC_MAKER_CODE_HIGH = 8'h1c;
  localparam logic [7:0] CSC_MAKER_CODE_LOW = 8'h1d;
  localparam logic [7:0] CSC_MIRROR_FLIP_CTRL = 8'h1e;
  localparam logic [7:0] CSC_RESERVED_1F = 8'h1f;
  localparam logic [7:0] CSC_BLUE_BLACK_OFFSET = 8'h20;
  localparam logic [7:0] CSC_GREEN_B_BLACK_OFFSET = 8'h21;
  localparam int CSC_NREG = 15;
  // Reset values, indexed by offset minus first offset
  localparam logic [7:0] CSC_RST [CSC_NREG] = '{
    8'h8f, 8'h4a, 8'h00, 8'h04, 8'h1a, 8'hba, 8'h01, 8'hb1,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h80};
  // Identification bytes, values arbitrary
  localparam logic [7:0] CSC_MAKER_HI = 8'h5a;
  localparam logic [7:0] CSC_MAKER_LO = 8'h3c;
  // Bus device address, value arbitrary
  localparam logic [6:0] CSC_DEV_ADDR = 7'h30;
  // Field positions
  localparam int AC_FAST = 7, AC_STEP = 6, AC_BAND = 5, AC_SUBLINE = 3;
  localparam int AC_AGC = 2, AC_AWB = 1, AC_AEC = 0;
  localparam int GC_CEIL = 4, GC_BANDOVR = 3, GC_VDROP = 2, GC_DROP = 1;
  localparam int SO_SLAVE = 7, SO_HSYNC = 6, SO_PGATE = 5, SO_PINV = 4;
  localparam int SO_LVINV = 3, SO_VSINV = 1, SO_HSINV = 0;
  localparam int OO_SAV = 6, OO_DUMMY = 4, OO_BLANK = 1;
  localparam int MF_MIRROR = 5, MF_FLIP = 4;
  // Dummy-frame gain thresholds and gain ceiling maximum, whole multiples
  localparam logic [7:0] CSC_DUMMY_2X = 8'h02;
  localparam logic [7:0] CSC_DUMMY_4X = 8'h04;
  localparam logic [7:0] CSC_DUMMY_8X = 8'h08;
  localparam logic [7:0] CSC_GAIN_MAX = 8'h80;
  // Serial slave states
  typedef enum logic [3:0] {
    CSC_IDLE, CSC_DEV, CSC_DEVACK, CSC_SUB, CSC_SUBACK,
    CSC_WR, CSC_WRACK, CSC_RD, CSC_RDACK, CSC_SKIP
  } csc_state_t;
endpackage : csc_pkg

/* File: csc_regs_properties.sv */
module csc_regs_properties (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic frameStart,
  input wire logic longStepOption,
  input wire logic [7:0] gainReq,
  input wire logic [15:0] expStep,
  input wire logic [15:0] expGap,
  input wire logic powerDownPin,
  input wire logic sdaOeN,
  input wire logic fastAlgoEn,
  input wire logic agcEn,
  input wire logic stepLimitVsync,
  input wire logic [7:0] gainCapped,
  input wire logic frameDropReq,
  input wire logic dummyFrameReq,
  input wire logic [1:0] savPosition,
  input wire logic [7:0] blueOffset,
  input wire logic slaveHorizSync,
  input wire logic slaveVertSync,
  input wire logic sensorResetReq,
  input wire logic powerDownReq
);
  timeunit 1ns;
  timeprecision 1ns;
  // One clock domain for every check
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  chk_step_limit: assert property (
    stepLimitVsync |-> fastAlgoEn && !$past(longStepOption)) else $error("step limit without cause");
  chk_gain_cap: assert property (
    gainCapped <= $past(gainReq) && gainCapped <= 8'h80) else $error("gain above request or ceiling");
  chk_drop_req: assert property (
    frameDropReq |-> $past(expStep) > $past(expGap)) else $error("frame drop without large step");
  chk_dummy_gain: assert property (
    dummyFrameReq |-> $past(gainReq) > 8'h02) else $error("dummy frame at low gain");
  chk_slave_pins: assert property (
    (slaveHorizSync || slaveVertSync) |-> !sensorResetReq && !powerDownReq) else $error("pin used twice");
  chk_slave_vsync: assert property (
    slaveVertSync |-> $past(powerDownPin)) else $error("slave vsync not from pin");
  chk_cfg_frame: assert property (
    !$past(sys_rst) && !$past(sys_rst, 2) && !$past(frameStart) && !$past(frameStart, 2)
    |-> $stable(agcEn) && $stable(blueOffset) && $stable(savPosition)) else $error("field changed mid frame");
  chk_rst_quiet: assert property (
    disable iff (1'b0) sys_rst |=> sdaOeN && !agcEn && !fastAlgoEn) else $error("outputs active in reset");
endmodule : csc_regs_properties

/* File: csc_host.sv */
module csc_host (
  input wire logic mclk,
  input wire logic sdaOeN,
  output logic sclIn,
  output logic sdaIn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic scl = 1'b1; // Serial clock, idle high
  logic sdaDrv = 1'b1; // Host data drive, high is released
  // Open-drain data line with pull-up
  assign sclIn = scl;
  assign sdaIn = sdaDrv & sdaOeN;

  // one bit, clock low five cycles, then high four cycles
  task automatic bitx(input logic b, output logic r);
    @(posedge mclk) sdaDrv <= b;
    repeat (4) @(posedge mclk);
    scl <= 1'b1;
    repeat (4) @(posedge mclk);
    r = sdaIn;
    scl <= 1'b0;
  endtask : bitx

  // Data falls while clock high
  task automatic startCond;
    @(posedge mclk) sdaDrv <= 1'b1;
    scl <= 1'b1;
    repeat (4) @(posedge mclk);
    sdaDrv <= 1'b0;
    repeat (4) @(posedge mclk);
    scl <= 1'b0;
  endtask : startCond

  // Data rises while clock high
  task automatic stopCond;
    @(posedge mclk) sdaDrv <= 1'b0;
    repeat (4) @(posedge mclk);
    scl <= 1'b1;
    repeat (4) @(posedge mclk);
    sdaDrv <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask : stopCond

  // whole bytes, first bit most significant
  task automatic sendByte(input logic [7:0] d, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, nak);
  endtask : sendByte

  // Read one byte, then refuse more
  task automatic recvByte(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(1'b1, r);
  endtask : recvByte

  task automatic writeReg(input logic [6:0] dev, input logic [7:0] sub, input logic [7:0] d, output logic nak);
    logic a0, a1, a2;
    startCond();
    sendByte({dev, 1'b0}, a0);
    sendByte(sub, a1);
    sendByte(d, a2);
    stopCond();
    nak = a0 | a1 | a2;
  endtask : writeReg

  // Set offset, then read from it
  task automatic readReg(input logic [7:0] sub, output logic [7:0] d);
    logic a;
    startCond();
    sendByte({csc_pkg::CSC_DEV_ADDR, 1'b0}, a);
    sendByte(sub, a);
    stopCond();
    startCond();
    sendByte({csc_pkg::CSC_DEV_ADDR, 1'b1}, a);
    recvByte(d);
    stopCond();
  endtask : readReg
endmodule : csc_host

/* File: csc_regs_tb.sv */
module csc_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, sys_rst = 1'b1, sclIn, sdaIn, frameStart = 1'b0, modeChange = 1'b0;
  logic longStepOption = 1'b0, windowAutoUpdate = 1'b0, resetPinN = 1'b1, powerDownPin = 1'b0;
  logic lineValidRaw = 1'b0, hsyncRaw = 1'b0, vsyncRaw = 1'b0, pclkRaw = 1'b0;
  logic [7:0] modeHStart = 8'h11, modeHEnd = 8'h22, modeVStart = 8'h33, modeVEnd = 8'h44, gainReq = 8'h00;
  logic [5:0] lineValidLow = 6'h00, vertRefLow = 6'h00;
  logic [15:0] expStep = 16'h0000, expGap = 16'h0000;
  logic sdaOut, sdaOeN, fastAlgoEn, agcEn, awbEn, aecEn, stepLimitVsync, bandFilterEn, subLineExpEn;
  logic bandLimitOverride, frameDropReq, dummyFrameReq, blankFillEn, mirrorEn, flipEn, lineValidOut;
  logic hsyncOut, vsyncOut, pclkOut, sensorResetReq, powerDownReq, slaveHorizSync, slaveVertSync;
  logic [7:0] gainCapped, pixelDelay, blueOffset, greenBOffset;
  logic [1:0] savPosition;
  logic [10:0] hWinStart, hWinEnd, vWinStart, vWinEnd;
  int num_errors = 0, checks_done = 0, cycles = 0; // Tallies and hang guard

  csc_regs dut_u (.*);
  csc_host host_u (.mclk(mclk), .sdaOeN(sdaOeN), .sclIn(sclIn), .sdaIn(sdaIn));

  // Free-running clock
  initial forever #25 mclk = ~mclk;

  task check(input logic [43:0] seen, input logic [43:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task results;
    if (num_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  task wr(input logic [7:0] a, input logic [7:0] d);
    logic n;
    host_u.writeReg(csc_pkg::CSC_DEV_ADDR, a, d, n);
    check(n, 1'b0);
  endtask : wr

  // Pulse frame start, wait for outputs
  task frame;
    @(posedge mclk) frameStart <= 1'b1;
    @(posedge mclk) frameStart <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask : frame

  task tst_reset;
    logic [7:0] v, e;
    for (int i = 0; i < csc_pkg::CSC_NREG; i++) begin
      host_u.readReg(8'h13 + 8'(i), v);
      e = (i == 9) ? csc_pkg::CSC_MAKER_HI : (i == 10) ? csc_pkg::CSC_MAKER_LO : csc_pkg::CSC_RST[i];
      check(v, e);
    end
    check({fastAlgoEn, agcEn, awbEn, aecEn, blueOffset}, {4'hf, 8'h80});
  endtask : tst_reset

  task tst_ro;
    logic [7:0] v;
    logic n;
    wr(8'h1c, 8'hff);
    host_u.readReg(8'h1c, v);
    check(v, csc_pkg::CSC_MAKER_HI);
    wr(8'h1f, 8'ha5);
    host_u.readReg(8'h1f, v);
    check(v, 8'ha5);
    wr(8'h40, 8'h77);
    host_u.readReg(8'h40, v);
    check(v, 8'h00);
    host_u.writeReg(7'h31, 8'h13, 8'h00, n);
    check(n, 1'b1);
  endtask : tst_ro

  task tst_frame;
    wr(8'h13, 8'h2f);
    check(fastAlgoEn, 1'b1);
    frame();
    check({fastAlgoEn, agcEn, awbEn, aecEn, subLineExpEn, bandFilterEn}, 6'h1f);
    wr(8'h13, 8'h80);
    frame();
    check(stepLimitVsync, 1'b1);
    @(posedge mclk) longStepOption <= 1'b1;
    repeat (2) @(posedge mclk);
    check(stepLimitVsync, 1'b0);
  endtask : tst_frame

  task tst_gain;
    logic [7:0] lim;
    @(posedge mclk) gainReq <= 8'hff;
    expStep <= 16'h0105;
    expGap <= 16'h0104;
    for (int c = 0; c < 8; c++) begin
      wr(8'h14, {1'b0, 3'(c), 4'h2});
      frame();
      lim = (c == 7) ? 8'h80 : 8'h02 << c;
      check(gainCapped, lim);
      check(frameDropReq, 1'b1);
    end
    @(posedge mclk) expGap <= 16'h0105;
    repeat (2) @(posedge mclk);
    check(frameDropReq, 1'b0);
  endtask : tst_gain

  task tst_dummy;
    logic [7:0] thr;
    for (int c = 0; c < 4; c++) begin
      thr = (c == 0) ? 8'h02 : (c == 1) ? 8'h04 : 8'h08;
      wr(8'h16, {2'b00, 2'(c), 4'h4});
      @(posedge mclk) gainReq <= thr;
      frame();
      check(dummyFrameReq, 1'b0);
      @(posedge mclk) gainReq <= thr + 8'h01;
      repeat (2) @(posedge mclk);
      check(dummyFrameReq, 1'b1);
    end
  endtask : tst_dummy

  task tst_sync;
    wr(8'h15, 8'h80);
    @(posedge mclk) resetPinN <= 1'b0;
    powerDownPin <= 1'b1;
    frame();
    check({slaveHorizSync, slaveVertSync, powerDownReq}, 3'h6);
    wr(8'h15, 8'h5b);
    @(posedge mclk) hsyncRaw <= 1'b1;
    pclkRaw <= 1'b1;
    frame();
    check({lineValidOut, hsyncOut, vsyncOut, pclkOut, sensorResetReq}, 5'h05);
    wr(8'h15, 8'h20);
    frame();
    check(pclkOut, 1'b0);
    @(posedge mclk) lineValidRaw <= 1'b1;
    vsyncRaw <= 1'b1;
    repeat (2) @(posedge mclk);
    check({pclkOut, vsyncOut}, 2'h3);
    // Vertical sync held off while a frame drops
    wr(8'h14, 8'h06);
    frame();
    check(vsyncOut, 1'b1);
    check(bandLimitOverride, 1'b0);
    @(posedge mclk) expGap <= 16'h0100;
    repeat (3) @(posedge mclk);
    check(vsyncOut, 1'b0);
  endtask : tst_sync

  // Format, delay, mirror and offset fields
  task tst_format;
    wr(8'h14, 8'h08);
    wr(8'h16, 8'hc2);
    wr(8'h1b, 8'h5a);
    wr(8'h1e, 8'h30);
    wr(8'h21, 8'h7f);
    frame();
    check(bandLimitOverride, 1'b1);
    check({savPosition, blankFillEn}, 3'h7);
    check(pixelDelay, 8'h5a);
    check({mirrorEn, flipEn, greenBOffset, sdaOut}, 11'h6fe);
  endtask : tst_format

  task tst_window;
    logic [7:0] v;
    @(posedge mclk) lineValidLow <= 6'h2d;
    vertRefLow <= 6'h0a;
    wr(8'h17, 8'h55);
    frame();
    check(hWinStart, {8'h55, 3'h5});
    @(posedge mclk) windowAutoUpdate <= 1'b1;
    modeChange <= 1'b1;
    @(posedge mclk) modeChange <= 1'b0;
    frame();
    check({hWinStart, hWinEnd, vWinStart, vWinEnd}, {8'h11, 3'h5, 8'h22, 3'h5, 8'h33, 3'h2, 8'h44, 3'h1});
    host_u.readReg(8'h19, v);
    check(v, 8'h33);
  endtask : tst_window

  // Main sequence
  initial begin
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge mclk);
    tst_reset();
    tst_ro();
    tst_frame();
    tst_gain();
    tst_dummy();
    tst_sync();
    tst_format();
    tst_window();
    results();
  end

  // Hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      results();
    end
  end
endmodule : csc_regs_tb

bind csc_regs csc_regs_properties chk_u (.*);
